// File: hdl/config_defaults.sv
`timescale 1ns/10ps
module config_defaults (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic warm_rst,
  input wire logic persist_cfg_load,
  input wire logic working_cfg_load,
  input wire logic int_cfg_load,
  input wire logic check_start_load,
  input wire logic check_end_load,
  input wire logic [flash_status_pkg::CFG_W-1:0] cfg_wdata,
  input wire logic [flash_status_pkg::CHECK_ADDR_W-1:0] addr_wdata,
  output logic [flash_status_pkg::CFG_W-1:0] persistent_config_word,
  output logic [flash_status_pkg::CFG_W-1:0] working_config_word,
  output logic [flash_status_pkg::CFG_W-1:0] interrupt_config_word,
  output logic [flash_status_pkg::CHECK_ADDR_W-1:0] check_start_address,
  output logic [flash_status_pkg::CHECK_ADDR_W-1:0] check_end_address
);
  // persistent word survives warm reset; only a cold reset models power-up
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      persistent_config_word <= flash_status_pkg::PERSIST_CFG_RESET;
    end else if (persist_cfg_load) begin
      persistent_config_word <= cfg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      working_config_word <= flash_status_pkg::PERSIST_CFG_RESET;
    end else if (warm_rst) begin
      working_config_word <= persistent_config_word;
    end else if (working_cfg_load) begin
      working_config_word <= cfg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || warm_rst) begin
      interrupt_config_word <= flash_status_pkg::INT_CFG_RESET;
      check_start_address <= flash_status_pkg::CHECK_ADDR_RESET;
      check_end_address <= flash_status_pkg::CHECK_ADDR_RESET;
    end else begin
      if (int_cfg_load) begin
        interrupt_config_word <= cfg_wdata;
      end
      if (check_start_load) begin
        check_start_address <= addr_wdata;
      end
      if (check_end_load) begin
        check_end_address <= addr_wdata;
      end
    end
  end

  a_cfg_warm_copy: assert property (@(posedge sys_clk) disable iff (srst)
    warm_rst |=> working_config_word == $past(persistent_config_word))
    else $error("working config not reloaded from persistent word");
  a_check_defaults: assert property (@(posedge sys_clk)
    (srst || warm_rst) |=> check_start_address == 26'h3FFFFFF
      && check_end_address == 26'h3FFFFFF && interrupt_config_word == 16'hFFFF)
    else $error("check range or interrupt config default wrong");
endmodule : config_defaults

// File: hdl/flash_status_ctrl.sv
`timescale 1ns/10ps
// Summary of operation
// - one 16-bit status word, read by status command then one read access
// - next read after status command returns status; then array reads resume
// - ready flag bit 7 is 0 while an algorithm runs, else 1; after crc_resume the code keeps it 1
// - bits 8 and 6:0 only meaningful while ready; host ignores them when busy
// - clear-status and software reset zero bits 5,4,3,1,0 only
// - cold or warm reset gives status word 0080h
// - bit 5 shows failure of most recent erase
// - bit 4 shows failure of most recent program
// - bit 3 set when program aborted during buffer load sequence
// - bit 6 set while erase suspended, cleared by erase resume
// - bit 2 set while program suspended, cleared by program resume
// - bit 8 set while check-value suspended; only array reads allowed then
// - bit 1 set when last program or erase hit a protected region
// - bit 0 holds erase check command result
// - program to suspended sector during erase suspend fails, sets bit 4
// - erase during erase suspend fails, sets bit 5
// - program or erase during program suspend fails, sets bit 4 or 5
// - working config loads persistent config at reset; persistent default 8EBBh
// - check start/end addresses 26 bits reset 3FFFFFFh; interrupt config FFFFh
module flash_status_ctrl (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic warm_rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic rd_req,
  input wire logic [flash_status_pkg::STATUS_W-1:0] array_rdata,
  input wire logic op_req,
  input wire flash_status_pkg::op_kind_e op_kind,
  input wire logic op_in_susp_sector,
  input wire logic alg_done,
  input wire logic done_fail,
  input wire logic done_abort,
  input wire logic done_locked,
  input wire logic done_check_ok,
  input wire logic erase_susp_done,
  input wire logic prog_susp_done,
  input wire logic crc_susp_done,
  input wire logic crc_resume,
  input wire logic persist_cfg_load,
  input wire logic working_cfg_load,
  input wire logic int_cfg_load,
  input wire logic check_start_load,
  input wire logic check_end_load,
  input wire logic [flash_status_pkg::CFG_W-1:0] cfg_wdata,
  input wire logic [flash_status_pkg::CHECK_ADDR_W-1:0] addr_wdata,
  output logic [flash_status_pkg::STATUS_W-1:0] rd_data_r,
  output logic rd_valid_r,
  output logic op_grant_r,
  output logic op_reject_r,
  output logic [flash_status_pkg::STATUS_W-1:0] algorithm_status_word,
  output logic [flash_status_pkg::CFG_W-1:0] persistent_config_word,
  output logic [flash_status_pkg::CFG_W-1:0] working_config_word,
  output logic [flash_status_pkg::CFG_W-1:0] interrupt_config_word,
  output logic [flash_status_pkg::CHECK_ADDR_W-1:0] check_start_address,
  output logic [flash_status_pkg::CHECK_ADDR_W-1:0] check_end_address
);
  // ****************************************
  // command decode
  // ****************************************
  logic any_rst, cmd_status, cmd_clear, cmd_erase_resume, cmd_prog_resume;
  logic embedded_algorithm_run, erase_suspended_flag, program_suspended_flag;
  logic crc_suspended_flag, erase_fail_flag, program_fail_flag, buffer_abort_flag;
  logic locked_target_flag, sector_erase_check_flag, overlay_space, rej_prog, rej_erase;
  logic rej_other, reject_now, grant_now, erase_resume_ok, prog_resume_ok;
  flash_status_pkg::op_kind_e run_kind_r;
  logic [flash_status_pkg::STATUS_W-1:0] status_now;

  assign any_rst = srst || warm_rst;
  assign cmd_status = cmd_valid && cmd_code == flash_status_pkg::CMD_STATUS_READ;
  assign cmd_clear = cmd_valid && (cmd_code == flash_status_pkg::CMD_CLEAR_STATUS
    || cmd_code == flash_status_pkg::CMD_SOFT_RESET);
  assign cmd_erase_resume = cmd_valid && cmd_code == flash_status_pkg::CMD_ERASE_RESUME;
  assign cmd_prog_resume = cmd_valid && cmd_code == flash_status_pkg::CMD_PROG_RESUME;
  // a resume while an algorithm is already running is ignored
  assign erase_resume_ok = cmd_erase_resume && erase_suspended_flag && !embedded_algorithm_run;
  assign prog_resume_ok = cmd_prog_resume && program_suspended_flag && !embedded_algorithm_run;

  // ****************************************
  // operation admission
  // ****************************************
  assign rej_prog = op_kind == flash_status_pkg::OP_PROGRAM
    && ((erase_suspended_flag && op_in_susp_sector) || program_suspended_flag);
  assign rej_erase = op_kind == flash_status_pkg::OP_ERASE
    && (erase_suspended_flag || program_suspended_flag);
  // a suspended check-value run leaves only array reads available
  assign rej_other = crc_suspended_flag || embedded_algorithm_run;
  assign reject_now = op_req && (rej_prog || rej_erase || rej_other);
  assign grant_now = op_req && !reject_now;

  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      op_grant_r <= 1'b0;
      op_reject_r <= 1'b0;
    end else begin
      op_grant_r <= grant_now;
      op_reject_r <= reject_now;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      run_kind_r <= flash_status_pkg::OP_ERASE;
    end else if (grant_now) begin
      run_kind_r <= op_kind;
    end else if (erase_resume_ok) begin
      run_kind_r <= flash_status_pkg::OP_ERASE;
    end else if (prog_resume_ok) begin
      run_kind_r <= flash_status_pkg::OP_PROGRAM;
    end
  end

  // ****************************************
  // state flags
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      embedded_algorithm_run <= 1'b0;
    end else if (grant_now || erase_resume_ok || prog_resume_ok) begin
      embedded_algorithm_run <= 1'b1;
    end else if (alg_done || erase_susp_done || prog_susp_done || crc_susp_done) begin
      embedded_algorithm_run <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      erase_suspended_flag <= 1'b0;
    end else if (erase_susp_done) begin
      erase_suspended_flag <= 1'b1;
    end else if (erase_resume_ok) begin
      erase_suspended_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      program_suspended_flag <= 1'b0;
    end else if (prog_susp_done) begin
      program_suspended_flag <= 1'b1;
    end else if (prog_resume_ok) begin
      program_suspended_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      crc_suspended_flag <= 1'b0;
    end else if (crc_susp_done) begin
      crc_suspended_flag <= 1'b1;
    end else if (crc_resume) begin
      crc_suspended_flag <= 1'b0;
    end
  end

  // ****************************************
  // result flags
  // ****************************************
  // a completion or rejection in the clear cycle overrides the clear
  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      erase_fail_flag <= 1'b0;
    end else if (reject_now && rej_erase) begin
      erase_fail_flag <= 1'b1;
    end else if (alg_done && run_kind_r == flash_status_pkg::OP_ERASE) begin
      erase_fail_flag <= done_fail;
    end else if (cmd_clear) begin
      erase_fail_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      program_fail_flag <= 1'b0;
    end else if (reject_now && rej_prog) begin
      program_fail_flag <= 1'b1;
    end else if (alg_done && run_kind_r == flash_status_pkg::OP_PROGRAM) begin
      program_fail_flag <= done_fail;
    end else if (cmd_clear) begin
      program_fail_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      buffer_abort_flag <= 1'b0;
    end else if (alg_done && run_kind_r == flash_status_pkg::OP_PROGRAM) begin
      buffer_abort_flag <= done_abort;
    end else if (cmd_clear) begin
      buffer_abort_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      locked_target_flag <= 1'b0;
    end else if (alg_done && (run_kind_r == flash_status_pkg::OP_PROGRAM
        || run_kind_r == flash_status_pkg::OP_ERASE)) begin
      locked_target_flag <= done_locked;
    end else if (cmd_clear) begin
      locked_target_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      sector_erase_check_flag <= 1'b0;
    end else if (alg_done && run_kind_r == flash_status_pkg::OP_ERASE_CHECK) begin
      sector_erase_check_flag <= done_check_ok;
    end else if (cmd_clear) begin
      sector_erase_check_flag <= 1'b0;
    end
  end

  // ****************************************
  // status word and overlay read
  // ****************************************
  // reserved bits 15:9 read zero so successive reads stay stable
  always_comb begin
    status_now = '0;
    status_now[flash_status_pkg::BIT_CRC_SUSP] = crc_suspended_flag;
    status_now[flash_status_pkg::BIT_READY] = !embedded_algorithm_run;
    status_now[flash_status_pkg::BIT_ERASE_SUSP] = erase_suspended_flag;
    status_now[flash_status_pkg::BIT_ERASE_FAIL] = erase_fail_flag;
    status_now[flash_status_pkg::BIT_PROG_FAIL] = program_fail_flag;
    status_now[flash_status_pkg::BIT_BUF_ABORT] = buffer_abort_flag;
    status_now[flash_status_pkg::BIT_PROG_SUSP] = program_suspended_flag;
    status_now[flash_status_pkg::BIT_LOCKED] = locked_target_flag;
    status_now[flash_status_pkg::BIT_ERASE_CHECK] = sector_erase_check_flag;
  end

  // flags stay visible while busy; the host must not trust them then
  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      algorithm_status_word <= flash_status_pkg::STATUS_RESET;
    end else begin
      algorithm_status_word <= status_now;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      overlay_space <= 1'b0;
    end else if (cmd_status) begin
      overlay_space <= 1'b1;
    end else if (rd_req) begin
      overlay_space <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      rd_valid_r <= 1'b0;
      rd_data_r <= '0;
    end else begin
      rd_valid_r <= rd_req;
      if (rd_req) begin
        rd_data_r <= overlay_space ? status_now : array_rdata;
      end
    end
  end

  config_defaults u_cfg (
    .sys_clk(sys_clk),
    .srst(srst),
    .warm_rst(warm_rst),
    .persist_cfg_load(persist_cfg_load),
    .working_cfg_load(working_cfg_load),
    .int_cfg_load(int_cfg_load),
    .check_start_load(check_start_load),
    .check_end_load(check_end_load),
    .cfg_wdata(cfg_wdata),
    .addr_wdata(addr_wdata),
    .persistent_config_word(persistent_config_word),
    .working_config_word(working_config_word),
    .interrupt_config_word(interrupt_config_word),
    .check_start_address(check_start_address),
    .check_end_address(check_end_address)
  );

  // ****************************************
  // checks
  // ****************************************
  sequence s_arm;
    cmd_status && !rd_req && !any_rst;
  endsequence
  sequence s_first_read;
    rd_req && overlay_space && !cmd_status;
  endsequence
  sequence s_array_read;
    (!rd_req && !cmd_status) ##1 (rd_req && !cmd_status);
  endsequence

  a_overlay_hit: assert property (@(posedge sys_clk) disable iff (any_rst)
    s_arm ##1 s_first_read |=> rd_valid_r && rd_data_r == $past(status_now))
    else $error("status overlay read did not return status word");
  a_overlay_once: assert property (@(posedge sys_clk) disable iff (any_rst)
    s_first_read ##1 s_array_read |=> rd_data_r == $past(array_rdata))
    else $error("overlay persisted past one read");
  a_read_timing: assert property (@(posedge sys_clk) disable iff (any_rst)
    s_arm ##1 s_first_read |=> rd_valid_r ##1 (rd_valid_r == $past(rd_req)))
    else $error("overlay read timing differs from array read");
  a_ready_busy: assert property (@(posedge sys_clk) disable iff (any_rst)
    grant_now |=> !status_now[7] ##0 (!status_now[7] throughout
      (!(alg_done || erase_susp_done || prog_susp_done || crc_susp_done)) [*1]))
    else $error("ready flag not cleared by algorithm start");
  a_clear_results: assert property (@(posedge sys_clk) disable iff (any_rst)
    (cmd_clear && !op_req && !alg_done) |=> (status_now & 16'h003B) == 16'h0000
      && status_now[8] == $past(status_now[8])
      && status_now[7:6] == $past(status_now[7:6])
      && status_now[2] == $past(status_now[2]))
    else $error("clear touched wrong bits");
  a_reset_word: assert property (@(posedge sys_clk) any_rst |=> algorithm_status_word == 16'h0080)
    else $error("status word not 0080h after reset");
  a_erase_result: assert property (@(posedge sys_clk) disable iff (any_rst)
    (alg_done && run_kind_r == flash_status_pkg::OP_ERASE && !reject_now)
      |=> erase_fail_flag == $past(done_fail) && status_now[7])
    else $error("erase fail flag wrong after erase");
  a_prog_result: assert property (@(posedge sys_clk) disable iff (any_rst)
    (alg_done && run_kind_r == flash_status_pkg::OP_PROGRAM && !reject_now)
      |=> program_fail_flag == $past(done_fail) && buffer_abort_flag == $past(done_abort))
    else $error("program result flags wrong");
  a_susp_reject: assert property (@(posedge sys_clk) disable iff (any_rst)
    (op_req && op_kind == flash_status_pkg::OP_ERASE && erase_suspended_flag)
      |=> op_reject_r && !op_grant_r && erase_fail_flag)
    else $error("erase during erase suspend not failed");
  a_crc_only_read: assert property (@(posedge sys_clk) disable iff (any_rst)
    (op_req && crc_suspended_flag) |=> op_reject_r ##1 !op_grant_r [*1])
    else $error("operation granted during check-value suspend");
endmodule : flash_status_ctrl

// File: hdl/flash_status_pkg.sv
package flash_status_pkg;
  // ****************************************
  // status word layout
  // ****************************************
  localparam int unsigned STATUS_W = 16;
  localparam int unsigned BIT_CRC_SUSP = 8;
  localparam int unsigned BIT_READY = 7;
  localparam int unsigned BIT_ERASE_SUSP = 6;
  localparam int unsigned BIT_ERASE_FAIL = 5;
  localparam int unsigned BIT_PROG_FAIL = 4;
  localparam int unsigned BIT_BUF_ABORT = 3;
  localparam int unsigned BIT_PROG_SUSP = 2;
  localparam int unsigned BIT_LOCKED = 1;
  localparam int unsigned BIT_ERASE_CHECK = 0;
  localparam logic [STATUS_W-1:0] STATUS_RESET = 16'h0080;
  localparam logic [STATUS_W-1:0] RESULT_MASK = 16'h003B;
  // ****************************************
  // command codes
  // ****************************************
  localparam logic [7:0] CMD_STATUS_READ = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h71;
  localparam logic [7:0] CMD_SOFT_RESET = 8'hF0;
  localparam logic [7:0] CMD_ERASE_RESUME = 8'h30;
  localparam logic [7:0] CMD_PROG_RESUME = 8'h31;
  // ****************************************
  // configuration and check-range defaults
  // ****************************************
  localparam int unsigned CFG_W = 16;
  localparam int unsigned CHECK_ADDR_W = 26;
  localparam logic [CFG_W-1:0] PERSIST_CFG_RESET = 16'h8EBB;
  localparam logic [CFG_W-1:0] INT_CFG_RESET = 16'hFFFF;
  localparam logic [CHECK_ADDR_W-1:0] CHECK_ADDR_RESET = 26'h3FFFFFF;
  // ****************************************
  // operation kinds
  // ****************************************
  typedef enum logic [1:0] {
    OP_ERASE,
    OP_PROGRAM,
    OP_CHECK_VALUE,
    OP_ERASE_CHECK
  } op_kind_e;
endpackage : flash_status_pkg

// File: tb/host_model.sv
`timescale 1ns/10ps
// ****************************************
// host side of the status read path
// ****************************************
module host_model (
  input wire logic sys_clk,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic rd_req,
  input wire logic [15:0] rd_data_r,
  input wire logic rd_valid_r
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    rd_req = 1'b0;
  end
  // trailing idle cycle so no strobe is lowered and raised in one step
  task automatic send_cmd(input logic [7:0] code);
    cmd_valid = 1'b1;
    cmd_code = code;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    cmd_code = ~code;
    @(negedge sys_clk);
  endtask : send_cmd
  task automatic read_word(output logic [15:0] d, output logic v);
    rd_req = 1'b1;
    @(negedge sys_clk);
    rd_req = 1'b0;
    d = rd_data_r;
    v = rd_valid_r;
    @(negedge sys_clk);
  endtask : read_word
  // read follows the command at once; reserved upper bits are dropped
  task automatic status(output logic [15:0] s, output logic v);
    cmd_valid = 1'b1;
    cmd_code = 8'h70;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    cmd_code = 8'h8F;
    rd_req = 1'b1;
    @(negedge sys_clk);
    rd_req = 1'b0;
    s = rd_data_r & 16'h01FF;
    v = rd_valid_r;
    @(negedge sys_clk);
  endtask : status
endmodule : host_model

// File: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  // ****************************************
  // stimulus and design
  // ****************************************
  logic sys_clk = 1'b0, srst = 1'b1, warm_rst = 1'b0, op_req = 1'b0, op_in_susp_sector = 1'b0;
  logic alg_done = 1'b0, done_fail = 1'b0, done_abort = 1'b0, done_locked = 1'b0;
  logic done_check_ok = 1'b0, erase_susp_done = 1'b0, prog_susp_done = 1'b0;
  logic crc_susp_done = 1'b0, crc_resume = 1'b0, persist_cfg_load = 1'b0;
  logic working_cfg_load = 1'b0, int_cfg_load = 1'b0, check_start_load = 1'b0;
  logic check_end_load = 1'b0;
  logic [25:0] addr_wdata = 26'h1555AAA;
  logic [15:0] array_rdata = 16'hA5C3, cfg_wdata = 16'h1234;
  flash_status_pkg::op_kind_e op_kind = flash_status_pkg::OP_ERASE;
  logic cmd_valid, rd_req, rd_valid_r, op_grant_r, op_reject_r, v;
  logic [7:0] cmd_code;
  logic [15:0] rd_data_r, algorithm_status_word, persistent_config_word, d;
  logic [15:0] working_config_word, interrupt_config_word;
  logic [25:0] check_start_address, check_end_address;
  int n_fail = 0, checks = 0;
  always #5 sys_clk = ~sys_clk;
  flash_status_ctrl uut (.sys_clk, .srst, .warm_rst, .cmd_valid, .cmd_code, .rd_req,
    .array_rdata, .op_req, .op_kind, .op_in_susp_sector, .alg_done, .done_fail,
    .done_abort, .done_locked, .done_check_ok, .erase_susp_done, .prog_susp_done,
    .crc_susp_done, .crc_resume, .persist_cfg_load, .working_cfg_load,
    .int_cfg_load, .check_start_load, .check_end_load, .cfg_wdata,
    .addr_wdata, .rd_data_r, .rd_valid_r, .op_grant_r, .op_reject_r,
    .algorithm_status_word, .persistent_config_word, .working_config_word,
    .interrupt_config_word, .check_start_address, .check_end_address);
  host_model host (.sys_clk, .cmd_valid, .cmd_code, .rd_req, .rd_data_r, .rd_valid_r);
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
    @(negedge sys_clk);
  endtask : pulse
  task automatic stat(input logic [15:0] exp);
    host.status(d, v);
    check(v, 1'b1);
    check(d, exp);
  endtask : stat
  // bounded poll; running out of tries ends the run
  task automatic poll(input logic [15:0] exp);
    int i;
    for (i = 0; i < 20; i++) begin
      host.status(d, v);
      if (d[7] === 1'b1) break;
    end
    check(d, exp);
    if (i == 20) begin
      n_fail++;
      stop_test();
    end
  endtask : poll
  task automatic op(input flash_status_pkg::op_kind_e k, input logic sec, input logic grant);
    op_kind = k;
    op_in_susp_sector = sec;
    op_req = 1'b1;
    @(negedge sys_clk);
    op_req = 1'b0;
    check(op_grant_r, grant);
    check(op_reject_r, !grant);
    @(negedge sys_clk);
  endtask : op
  task automatic done(input logic [3:0] f);
    {done_fail, done_abort, done_locked, done_check_ok} = f;
    pulse(alg_done);
    {done_fail, done_abort, done_locked, done_check_ok} = 4'h0;
  endtask : done
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [7:0] clr [2] = '{8'h71, 8'hF0};
    repeat (3) @(negedge sys_clk);
    srst = 1'b0;
    stat(16'h0080);
    check(algorithm_status_word, 16'h0080);
    check(persistent_config_word, 16'h8EBB);
    check(working_config_word, 16'h8EBB);
    check(interrupt_config_word, 16'hFFFF);
    check(check_start_address, 26'h3FFFFFF);
    check(check_end_address, 26'h3FFFFFF);
    stat(16'h0080);
    host.read_word(d, v);
    check(d, 16'hA5C3);
    op(flash_status_pkg::OP_ERASE, 1'b0, 1'b1);
    host.status(d, v);
    check(d[7], 1'b0);
    done(4'b1000);
    poll(16'h00A0);
    op(flash_status_pkg::OP_ERASE, 1'b0, 1'b1);
    done(4'b0000);
    poll(16'h0080);
    foreach (clr[i]) begin
      op(flash_status_pkg::OP_PROGRAM, 1'b0, 1'b1);
      done(4'b1110);
      poll(16'h009A);
      op(flash_status_pkg::OP_ERASE_CHECK, 1'b0, 1'b1);
      done(4'b0001);
      poll(16'h009B);
      host.send_cmd(clr[i]);
      stat(16'h0080);
    end
    op(flash_status_pkg::OP_ERASE, 1'b0, 1'b1);
    pulse(erase_susp_done);
    poll(16'h00C0);
    check(algorithm_status_word & 16'h01FF, 16'h00C0);
    op(flash_status_pkg::OP_PROGRAM, 1'b1, 1'b0);
    stat(16'h00D0);
    op(flash_status_pkg::OP_PROGRAM, 1'b0, 1'b1);
    done(4'b0000);
    poll(16'h00C0);
    op(flash_status_pkg::OP_ERASE, 1'b0, 1'b0);
    stat(16'h00E0);
    host.send_cmd(8'h71);
    stat(16'h00C0);
    host.send_cmd(8'h30);
    host.status(d, v);
    check(d[7:6], 2'b00);
    done(4'b0000);
    poll(16'h0080);
    op(flash_status_pkg::OP_PROGRAM, 1'b0, 1'b1);
    pulse(prog_susp_done);
    poll(16'h0084);
    op(flash_status_pkg::OP_PROGRAM, 1'b0, 1'b0);
    stat(16'h0094);
    op(flash_status_pkg::OP_ERASE, 1'b0, 1'b0);
    stat(16'h00B4);
    host.send_cmd(8'h31);
    host.status(d, v);
    check({d[7], d[2]}, 2'b00);
    done(4'b0000);
    poll(16'h00A0);
    op(flash_status_pkg::OP_CHECK_VALUE, 1'b0, 1'b1);
    pulse(crc_susp_done);
    poll(16'h01A0);
    op(flash_status_pkg::OP_ERASE, 1'b0, 1'b0);
    pulse(crc_resume);
    host.status(d, v);
    check(d[8], 1'b0);
    pulse(persist_cfg_load);
    check(persistent_config_word, 16'h1234);
    pulse(int_cfg_load);
    check(interrupt_config_word, 16'h1234);
    pulse(check_start_load);
    pulse(check_end_load);
    check(check_start_address, 26'h1555AAA);
    check(check_end_address, 26'h1555AAA);
    cfg_wdata = 16'h5A5A;
    pulse(working_cfg_load);
    check(working_config_word, 16'h5A5A);
    pulse(warm_rst);
    stat(16'h0080);
    check(working_config_word, 16'h1234);
    check(interrupt_config_word, 16'hFFFF);
    check(check_start_address, 26'h3FFFFFF);
    check(check_end_address, 26'h3FFFFFF);
    pulse(srst);
    check(working_config_word, 16'h8EBB);
    stop_test();
  end
endmodule : tb_top
